// ---- src/exec_pkg.sv ----
// Constants shared by the arithmetic/stack execution block.
// Assumes a single clock domain and AHB-Lite register access.
package exec_pkg;
   // Register byte offsets (chosen map)
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_INSTR    = 8'h04;
   localparam logic [7:0] OFF_ACC      = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0C;
   localparam logic [7:0] OFF_PROD     = 8'h10;
   localparam logic [7:0] OFF_BANK     = 8'h14;
   localparam logic [7:0] OFF_PC       = 8'h18;
   localparam logic [7:0] OFF_STACK    = 8'h1C;
   localparam logic [7:0] OFF_FILE     = 8'h20;
   localparam logic [7:0] OFF_FILEDATA = 8'h24;
   // Operation codes written to the instruction register bits 18:16
   localparam logic [2:0] OP_NOP  = 3'h0;
   localparam logic [2:0] OP_ADDL = 3'h1;
   localparam logic [2:0] OP_ADDF = 3'h2;
   localparam logic [2:0] OP_MULL = 3'h3;
   localparam logic [2:0] OP_MULF = 3'h4;
   localparam logic [2:0] OP_PUSH = 3'h5;
   localparam logic [2:0] OP_POP  = 3'h6;
   // Instruction word field positions
   localparam int OPC_LSB  = 16;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   // Status flag positions
   localparam int FLAG_C  = 0;
   localparam int FLAG_HC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_RANGE = 3;
   localparam int FLAG_N  = 4;
   // Sizes
   localparam int STACK_DEPTH = 31;
   localparam int PC_W        = 21;
   localparam logic [20:0] PC_STEP = 21'h00_0002;
   localparam logic [7:0] ACCESS_BANK = 8'h00;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   // Instruction phases
   typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} phase_t;
endpackage : exec_pkg

// ---- src/exec_if.sv ----
// Operand path between the sequencer and the arithmetic unit.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface exec_if;
   logic [7:0]  acc;       // Accumulator operand
   logic [7:0]  opnd;      // Literal or file operand
   logic [8:0]  sum;       // Sum with carry out
   logic        half;      // Carry out of low nibble
   logic        ovf;       // Signed range overflow
   logic [15:0] prod;      // Unsigned product
   modport seq (output acc, output opnd, input sum, input half,
                input ovf, input prod);
   modport alu (input acc, input opnd, output sum, output half,
                output ovf, output prod);
endinterface : exec_if

// ---- src/exec_alu.sv ----
// Combinational adder and multiplier for the execution block.
// Assumes operands are stable while the sequencer reads the results.
`timescale 1ns/1ps
module exec_alu (
   // Operand carrier
   exec_if.alu x
);
   logic [4:0] low_sum;    // Low nibble sum for half carry

   // Add and multiply in parallel; the sequencer picks one
   always_comb begin
      low_sum = {1'b0, x.acc[3:0]} + {1'b0, x.opnd[3:0]};
      x.sum   = {1'b0, x.acc} + {1'b0, x.opnd};
      x.half  = low_sum[4];
      // Overflow when both signs agree and the result sign differs
      x.ovf   = (x.acc[7] == x.opnd[7]) && (x.sum[7] != x.acc[7]);
      x.prod  = {8'h00, x.acc} * {8'h00, x.opnd};
   end
endmodule : exec_alu

// ---- src/exec_stack.sv ----
// Return stack memory with push and pop, top kept in the array.
// Assumes push and pop are never asked in the same cycle.
`timescale 1ns/1ps
module exec_stack (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Stack commands
   input  wire logic              push,
   input  wire logic              pop,
   input  wire logic [20:0]       push_val,
   // State
   output logic [20:0]            stack_top,
   output logic [4:0]             depth
);
   logic [20:0] mem_q [exec_pkg::STACK_DEPTH];  // Entry 0 is the top
   logic [20:0] mem_d [exec_pkg::STACK_DEPTH];
   logic [4:0]  depth_q, depth_d;

   // Shift entries down on push, up on pop
   always_comb begin
      mem_d   = mem_q;
      depth_d = depth_q;
      if (push) begin
         mem_d[0] = push_val;
         for (int i = 1; i < exec_pkg::STACK_DEPTH; i++) begin
            mem_d[i] = mem_q[i-1];
         end
         if (depth_q != 5'(exec_pkg::STACK_DEPTH)) depth_d = depth_q + 5'd1;
      end else if (pop) begin
         // Old top is dropped, not copied anywhere
         for (int i = 0; i < exec_pkg::STACK_DEPTH - 1; i++) begin
            mem_d[i] = mem_q[i+1];
         end
         mem_d[exec_pkg::STACK_DEPTH-1] = '0;
         if (depth_q != 5'd0) depth_d = depth_q - 5'd1;
      end
   end

   // Register the stack; ce freezes it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < exec_pkg::STACK_DEPTH; i++) mem_q[i] <= '0;
         depth_q <= '0;
      end else if (ce) begin
         mem_q   <= mem_d;
         depth_q <= depth_d;
      end
   end

   assign stack_top = mem_q[0];
   assign depth     = depth_q;
endmodule : exec_stack

// ---- src/arith_stack_instr_exec.sv ----
// Top of the execution block: AHB-Lite registers, four-phase sequencer,
// 256-byte file memory with access bank and bank select.
// Assumes a single AHB-Lite master and word-only transfers.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
//
// Behaviour
// - Add literal to accumulator, set flags
// - Add-register carries address, destination, bank bits
// - Multiply literal writes product in phase four
// - Multiply register gives full 16-bit product
// - Product high byte high, low byte low
// - Multiplies leave accumulator and register alone
// - Multiplies never touch any status flag
// - Bank bit zero: access bank, one: bank select
// - Push writes program counter plus two
// - Push moves old top one level down
// - Push acts in phase two only
// - Pop discards the top entry
// - After pop, previous entry is top
module arith_stack_instr_exec (
   // Clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Core status
   output logic             busy
);
   // All state is here, under one ce gate;
   // only the return stack lives apart.
   // Register state
   logic [31:0] instr_q, instr_d;        // Instruction word
   logic [7:0]  acc_q, acc_d;            // Accumulator
   logic [4:0]  flags_q, flags_d;        // Neg range zero half carry
   logic [7:0]  prod_hi_q, prod_hi_d;    // product_high
   logic [7:0]  prod_lo_q, prod_lo_d;    // product_low
   logic [3:0]  bank_q, bank_d;          // bank_select_register
   logic [20:0] pc_q, pc_d;              // Program counter
   logic [7:0]  fptr_q, fptr_d;          // Software file pointer
   logic [7:0]  file_q [256];            // File register memory
   logic        busy_q, busy_d;          // Instruction in flight
   exec_pkg::phase_t ph_q, ph_d;         // Current phase
   logic [7:0]  opnd_q, opnd_d;          // Operand latched in phase two
   // Address phase is caught here, and the write
   // is applied a cycle later when hwdata stands.
   // Bus data-phase state
   logic        wr_q, wr_d;
   logic        rd_q, rd_d;
   logic [7:0]  addr_q, addr_d;
   logic [31:0] rdata_q, rdata_d;
   // Wires decoded from instr_q and the stack
   // Decoded fields
   logic [2:0]  opc;
   logic [7:0]  fidx;                    // Resolved file address
   logic        dest_reg;
   logic        file_we;
   logic [7:0]  file_wa, file_wd;
   logic        st_push, st_pop;
   logic [20:0] st_top;
   logic [4:0]  st_depth;
   logic        bus_take;

   // Both results are always formed; the write
   // phase keeps one. Area traded for flat control.
   exec_if ex ();

   // Adder and multiplier on the carrier
   exec_alu u_alu (
      .x (ex.alu)
   );

   // Next-word address is formed here, so the
   // stack needs no view of the program counter.
   // A push on a full stack drops the oldest entry.
   exec_stack u_stack (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ce       (ce),
      .push     (st_push),
      .pop      (st_pop),
      .push_val (pc_q + exec_pkg::PC_STEP),
      .stack_top(st_top),
      .depth    (st_depth)
   );

   // Banks are 16 bytes: only f[3:0] reaches the
   // memory, and the bank bit picks the upper nibble.
   // Field decode from the instruction word
   assign opc      = instr_q[exec_pkg::OPC_LSB +: 3];
   assign dest_reg = instr_q[exec_pkg::DEST_BIT];
   // Bank bit 0 picks the access bank regardless of bank select
   assign fidx = instr_q[exec_pkg::BANK_BIT] ?
                 {bank_q, instr_q[3:0]} :
                 {exec_pkg::ACCESS_BANK[3:0], instr_q[3:0]};
   // Transfer accepted when selected, ready, NONSEQ or SEQ
   assign bus_take = hsel && hready && htrans[1];
   // Operands for the arithmetic unit
   assign ex.acc   = acc_q;
   assign ex.opnd  = opnd_q;

   // One process forms every next value, so the
   // bus and the sequencer cannot disagree about
   // who owns a register in a given cycle.
   // Sequencer and bus register next-state logic
   always_comb begin
      instr_d   = instr_q;
      acc_d     = acc_q;
      flags_d   = flags_q;
      prod_hi_d = prod_hi_q;
      prod_lo_d = prod_lo_q;
      bank_d    = bank_q;
      pc_d      = pc_q;
      fptr_d    = fptr_q;
      busy_d    = busy_q;
      ph_d      = ph_q;
      opnd_d    = opnd_q;
      // File port defaults to the instruction result
      file_we   = 1'b0;
      file_wa   = fidx;
      file_wd   = ex.sum[7:0];
      // Stack idle unless a phase asks
      st_push   = 1'b0;
      st_pop    = 1'b0;
      // Data-phase flags follow every taken phase
      wr_d      = bus_take && hwrite;
      rd_d      = bus_take && !hwrite;
      addr_d    = bus_take ? haddr[7:0] : addr_q;
      // Read data stands until the next read
      rdata_d   = rdata_q;

      // A new instruction is accepted only after the last ends
      // Four phases per instruction
      if (busy_q) begin
         case (ph_q)
            // Phase one: fields already sit in instr_q
            exec_pkg::PH_DECODE: ph_d = exec_pkg::PH_READ;
            // Phase two: operand fetch, and the push
            exec_pkg::PH_READ: begin
               ph_d = exec_pkg::PH_PROC;
               // Literal or file operand
               if (opc == exec_pkg::OP_ADDF || opc == exec_pkg::OP_MULF)
                  opnd_d = file_q[fidx];
               else
                  opnd_d = instr_q[7:0];
               // The push moves the stack here and nowhere later
               if (opc == exec_pkg::OP_PUSH) st_push = 1'b1;
            end
            // Phase three: only the pop acts
            exec_pkg::PH_PROC: begin
               ph_d = exec_pkg::PH_WRITE;
               if (opc == exec_pkg::OP_POP) st_pop = 1'b1;
            end
            // Phase four: results, flags, next address
            exec_pkg::PH_WRITE: begin
               ph_d   = exec_pkg::PH_DECODE;
               busy_d = 1'b0;
               pc_d   = pc_q + exec_pkg::PC_STEP;
               case (opc)
                  exec_pkg::OP_ADDL, exec_pkg::OP_ADDF: begin
                     // Result to register only for add-register with d=1
                     if (opc == exec_pkg::OP_ADDF && dest_reg)
                        file_we = 1'b1;
                     else
                        acc_d = ex.sum[7:0];
                     // Flags follow the sum whatever its target
                     flags_d[exec_pkg::FLAG_C]  = ex.sum[8];
                     flags_d[exec_pkg::FLAG_HC] = ex.half;
                     flags_d[exec_pkg::FLAG_Z]  = ex.sum[7:0] ==
                                                  exec_pkg::BYTE_ZERO;
                     flags_d[exec_pkg::FLAG_RANGE] = ex.ovf;
                     flags_d[exec_pkg::FLAG_N]  = ex.sum[7];
                  end
                  // No flag, not even zero, for a product
                  exec_pkg::OP_MULL, exec_pkg::OP_MULF: begin
                     // Flags and acc untouched; only product written
                     prod_hi_d = ex.prod[15:8];
                     prod_lo_d = ex.prod[7:0];
                  end
                  default: ;
               endcase
            end
            // Unreachable; recover to decode
            default: ph_d = exec_pkg::PH_DECODE;
         endcase
      end

      // Writes while busy are dropped, not stalled:
      // a stall would cost a wait state, and software
      // polls the busy bit first anyway.
      // Bus writes land in the data phase; ignored while busy
      if (wr_q && !busy_q) begin
         case (addr_q)
            // Instruction write starts the sequencer
            exec_pkg::OFF_INSTR: begin
               instr_d = hwdata;
               busy_d  = 1'b1;
               ph_d    = exec_pkg::PH_DECODE;
            end
            exec_pkg::OFF_ACC:   acc_d = hwdata[7:0];
            exec_pkg::OFF_STATUS: flags_d = hwdata[4:0];
            exec_pkg::OFF_BANK:  bank_d = hwdata[3:0];
            exec_pkg::OFF_PC:    pc_d = hwdata[20:0];
            exec_pkg::OFF_FILE:  fptr_d = hwdata[7:0];
            // File byte at the software pointer
            exec_pkg::OFF_FILEDATA: begin
               file_we = 1'b1;
               file_wa = fptr_q;
               file_wd = hwdata[7:0];
            end
            default: ;
         endcase
      end

      // Reads are served while busy, so software
      // can watch busy and the stack mid-instruction.
      // Read mux, sampled at the address phase
      if (bus_take && !hwrite) begin
         case (haddr[7:0])
            // Depth above the busy bit
            exec_pkg::OFF_CTRL:     rdata_d = {26'h0, st_depth, busy_q};
            exec_pkg::OFF_INSTR:    rdata_d = instr_q;
            exec_pkg::OFF_ACC:      rdata_d = {24'h0, acc_q};
            exec_pkg::OFF_STATUS:   rdata_d = {27'h0, flags_q};
            exec_pkg::OFF_PROD:     rdata_d = {16'h0, prod_hi_q, prod_lo_q};
            exec_pkg::OFF_BANK:     rdata_d = {28'h0, bank_q};
            exec_pkg::OFF_PC:       rdata_d = {11'h0, pc_q};
            exec_pkg::OFF_STACK:    rdata_d = {11'h0, st_top};
            exec_pkg::OFF_FILE:     rdata_d = {24'h0, fptr_q};
            exec_pkg::OFF_FILEDATA: rdata_d = {24'h0, file_q[fptr_q]};
            // Holes in the map read zero
            default:                rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // With ce low nothing moves, the data phase
   // included; hreadyout follows ce so that the
   // master holds its phase meanwhile.
   // Register everything; ce freezes all state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         // Idle, empty, program counter at zero
         instr_q   <= '0;
         acc_q     <= '0;
         flags_q   <= '0;
         prod_hi_q <= '0;
         prod_lo_q <= '0;
         bank_q    <= '0;
         pc_q      <= '0;
         fptr_q    <= '0;
         busy_q    <= 1'b0;
         ph_q      <= exec_pkg::PH_DECODE;
         opnd_q    <= '0;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         addr_q    <= '0;
         rdata_q   <= '0;
      end else if (ce) begin
         // Every register takes its next value
         instr_q   <= instr_d;
         acc_q     <= acc_d;
         flags_q   <= flags_d;
         prod_hi_q <= prod_hi_d;
         prod_lo_q <= prod_lo_d;
         bank_q    <= bank_d;
         pc_q      <= pc_d;
         fptr_q    <= fptr_d;
         busy_q    <= busy_d;
         ph_q      <= ph_d;
         opnd_q    <= opnd_d;
         wr_q      <= wr_d;
         rd_q      <= rd_d;
         addr_q    <= addr_d;
         rdata_q   <= rdata_d;
      end
   end

   // Unwritten file bytes read unknown;
   // software fills a location before use.
   // File memory; no reset so it maps to RAM
   always_ff @(posedge sys_clk) begin
      if (ce && file_we) file_q[file_wa] <= file_wd;
   end

   // No error response exists: unmapped reads
   // give zero and unmapped writes vanish.
   // Zero wait states, always OKAY; ready drops while ce is low
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   // Read data comes straight from a flip-flop
   assign hrdata    = rdata_q;
   assign busy      = busy_q;
endmodule : arith_stack_instr_exec

// ---- sim/exec_chk.sv ----
// Concurrent checks on the bus and busy ports of the execution block.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module exec_chk (
   // Clock, reset, enable
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        ce,
   // Bus inputs
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   // Design outputs
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        busy
);
   default clocking dck @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Address phase taken only while ready and enabled
   wire logic take = hsel && hready && htrans[1] && ce;
   // Read address phase at one register
   sequence s_rd(logic [7:0] a);
      take && !hwrite && haddr == {24'h00_0000, a};
   endsequence
   // Instruction issue: address phase of a write to the instruction word
   sequence s_instr;
      take && hwrite && haddr == {24'h00_0000, exec_pkg::OFF_INSTR};
   endsequence
   // Busy run length; a stuck busy shows as a count above four
   logic [2:0] busy_cnt_q;
   logic [2:0] busy_cnt_d;
   // Counts only enabled cycles, since ce low freezes the sequencer
   always_comb begin
      busy_cnt_d = busy_cnt_q;
      if (!busy) busy_cnt_d = 3'h0;
      else if (ce) busy_cnt_d = busy_cnt_q + 3'h1;
   end
   // Registers the count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) busy_cnt_q <= 3'h0;
      else busy_cnt_q <= busy_cnt_d;
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_ready_ce: assert property (hreadyout == ce)
      else $error("hreadyout differs from ce");
   a_instr_len: assert property (
      disable iff (rst || !ce) s_instr ##1 !busy |=> busy [*4] ##1 !busy)
      else $error("busy not four cycles after an instruction");
   a_busy_cause: assert property ($rose(busy) |->
      $past(take && hwrite && haddr[7:0] == exec_pkg::OFF_INSTR, 2))
      else $error("busy rose without an instruction write");
   a_busy_bound: assert property (busy_cnt_q <= 3'h4)
      else $error("busy held past four enabled cycles");
   a_rst_quiet: assert property (disable iff (1'b0)
      rst |=> !busy && hrdata == 32'h0000_0000)
      else $error("outputs not quiet in reset");
   a_unmapped_zero: assert property (take && !hwrite &&
      haddr[31:8] == 24'h00_0000 && haddr[7:0] > 8'h27
      |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_prod_width: assert property (
      s_rd(exec_pkg::OFF_PROD) |=> hrdata[31:16] == 16'h0000)
      else $error("product wider than 16 bits");
   a_acc_width: assert property (
      s_rd(exec_pkg::OFF_ACC) |=> hrdata[31:8] == 24'h00_0000)
      else $error("accumulator wider than 8 bits");
   a_flag_width: assert property (
      s_rd(exec_pkg::OFF_STATUS) |=> hrdata[31:5] == 27'h000_0000)
      else $error("status wider than five flags");
endmodule : exec_chk

bind arith_stack_instr_exec exec_chk exec_chk_i (
   .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .busy(busy));

// ---- sim/prog_mem.sv ----
// Program memory model: a table of instruction words fetched by index.
// Assumes the bench copies each fetched word into the instruction register.
`timescale 1ns/1ps
module prog_mem (
   // Fetch
   input  wire logic [3:0]  idx,
   output logic      [31:0] word
);
   // One program word per instruction
   logic [31:0] rom [10];
   // Packs opcode, destination, bank bit and literal or file address
   function automatic logic [31:0] enc(logic [2:0] op, logic d, logic a,
                                       logic [7:0] k);
      return {13'h0000, op, 6'h00, d, a, k};
   endfunction : enc
   // Fixed program; upper address bits in entry 2 probe the access bank
   initial begin
      rom[0] = enc(exec_pkg::OP_ADDL, 1'b0, 1'b0, 8'h15);
      rom[1] = enc(exec_pkg::OP_ADDL, 1'b0, 1'b0, 8'h01);
      rom[2] = enc(exec_pkg::OP_ADDF, 1'b0, 1'b0, 8'hA5);
      rom[3] = enc(exec_pkg::OP_ADDF, 1'b1, 1'b1, 8'h05);
      rom[4] = enc(exec_pkg::OP_MULL, 1'b0, 1'b0, 8'hC4);
      rom[5] = enc(exec_pkg::OP_MULF, 1'b0, 1'b1, 8'h05);
      rom[6] = enc(exec_pkg::OP_PUSH, 1'b0, 1'b0, 8'h00);
      rom[7] = enc(exec_pkg::OP_POP, 1'b0, 1'b0, 8'h00);
      rom[8] = enc(exec_pkg::OP_MULL, 1'b0, 1'b0, 8'hFF);
      rom[9] = enc(exec_pkg::OP_MULF, 1'b0, 1'b0, 8'h05);
   end
   // Combinational fetch; out-of-table indices read unknown
   assign word = rom[idx];
endmodule : prog_mem

// ---- sim/tb.sv ----
// Self-checking bench for the arithmetic and stack execution block.
// Assumes zero-wait AHB-Lite answers; hsel and hsize are held fixed.
`timescale 1ns/1ps
module tb;
   // Clock, reset, enable and bus
   logic        sys_clk;
   logic        rst;
   logic        ce;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic        busy;
   // Program fetch and score keeping
   logic [3:0]  idx;
   logic [31:0] word;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   // Add cases: start value, program entry, sum, flag bits 4 to 0
   logic [31:0] a_in [3] = '{32'h0000_0010, 32'h0000_007F, 32'h0000_00FF};
   logic [3:0]  a_op [3] = '{4'h0, 4'h1, 4'h1};
   logic [31:0] a_sum [3] = '{32'h0000_0025, 32'h0000_0080, 32'h0000_0000};
   logic [31:0] a_flg [3] = '{32'h0000_0000, 32'h0000_001A, 32'h0000_0007};
   arith_stack_instr_exec arith_stack_instr_exec_i (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .busy(busy));
   prog_mem prog_mem_i (.idx(idx), .word(word));
   // Clock of 4 ns
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Hang guard; the tests need under two thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : check
   // One transfer; each phase is held until hready is sampled high
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q);
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(logic [7:0] a, logic [31:0] exp, string what);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0000_0000, q);
      check(what, exp, q);
   endtask : rdc
   // Fetches entry n and writes it to the instruction register
   task automatic issue(logic [3:0] n);
      idx <= n;
      @(posedge sys_clk);
      wr(exec_pkg::OFF_INSTR, word);
   endtask : issue
   // Polls the busy bit, bounded so a stuck busy fails here
   task automatic idle();
      logic [31:0] s;
      s = 32'h0000_0001;
      for (int i = 0; i < 16 && s[0] !== 1'b0; i++)
         xfer(1'b0, exec_pkg::OFF_CTRL, 32'h0000_0000, s);
      check("busy clear", 32'h0000_0000, {31'h0000_0000, s[0]});
   endtask : idle
   // Main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      hsel = 1'b1;
      hsize = 3'b010;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      idx = 4'h0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdc(8'h80, 32'h0000_0000, "unmapped read");
      for (int i = 0; i < 3; i++) begin
         wr(exec_pkg::OFF_ACC, a_in[i]);
         issue(a_op[i]);
         idle();
         rdc(exec_pkg::OFF_ACC, a_sum[i], "acc sum");
         rdc(exec_pkg::OFF_STATUS, a_flg[i], "add flags");
      end
      wr(exec_pkg::OFF_ACC, 32'h0000_00E2);
      issue(4'h4);
      idle();
      rdc(exec_pkg::OFF_PROD, 32'h0000_AD08, "product lit");
      rdc(exec_pkg::OFF_ACC, 32'h0000_00E2, "acc after mul");
      rdc(exec_pkg::OFF_STATUS, 32'h0000_0007, "flags mul");
      wr(exec_pkg::OFF_ACC, 32'h0000_00FF);
      issue(4'h8);
      idle();
      rdc(exec_pkg::OFF_PROD, 32'h0000_FE01, "product max");
      wr(exec_pkg::OFF_BANK, 32'h0000_0003);
      wr(exec_pkg::OFF_FILE, 32'h0000_0005);
      wr(exec_pkg::OFF_FILEDATA, 32'h0000_00C2);
      wr(exec_pkg::OFF_FILE, 32'h0000_0035);
      wr(exec_pkg::OFF_FILEDATA, 32'h0000_00B5);
      wr(exec_pkg::OFF_ACC, 32'h0000_0000);
      issue(4'h9);
      idle();
      rdc(exec_pkg::OFF_PROD, 32'h0000_0000, "product zero");
      rdc(exec_pkg::OFF_STATUS, 32'h0000_0007, "zero unflagged");
      wr(exec_pkg::OFF_ACC, 32'h0000_00C4);
      issue(4'h5);
      idle();
      rdc(exec_pkg::OFF_PROD, 32'h0000_8A94, "product reg");
      rdc(exec_pkg::OFF_FILEDATA, 32'h0000_00B5, "file kept");
      wr(exec_pkg::OFF_ACC, 32'h0000_0017);
      issue(4'h2);
      idle();
      rdc(exec_pkg::OFF_ACC, 32'h0000_00D9, "access bank");
      rdc(exec_pkg::OFF_STATUS, 32'h0000_0010, "reg add flags");
      issue(4'h3);
      idle();
      rdc(exec_pkg::OFF_FILEDATA, 32'h0000_008E, "to reg");
      rdc(exec_pkg::OFF_ACC, 32'h0000_00D9, "acc kept");
      rdc(exec_pkg::OFF_STATUS, 32'h0000_0011, "carry flags");
      wr(exec_pkg::OFF_PC, 32'h0000_0124);
      issue(4'h6);
      idle();
      rdc(exec_pkg::OFF_STACK, 32'h0000_0126, "push top");
      issue(4'h6);
      rdc(exec_pkg::OFF_STACK, 32'h0000_0126, "top in decode");
      rdc(exec_pkg::OFF_STACK, 32'h0000_0128, "top in proc");
      idle();
      rdc(exec_pkg::OFF_STACK, 32'h0000_0128, "second push");
      rdc(exec_pkg::OFF_CTRL, 32'h0000_0004, "depth two");
      issue(4'h7);
      idle();
      rdc(exec_pkg::OFF_STACK, 32'h0000_0126, "pop top");
      rdc(exec_pkg::OFF_CTRL, 32'h0000_0002, "depth one");
      rdc(exec_pkg::OFF_PC, 32'h0000_012A, "pc step");
      wr(exec_pkg::OFF_ACC, 32'h0000_0010);
      issue(4'h0);
      wr(exec_pkg::OFF_ACC, 32'h0000_0055);
      idle();
      rdc(exec_pkg::OFF_ACC, 32'h0000_0025, "write in busy");
      issue(4'h1);
      ce <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check("busy frozen", 32'h0000_0001, {31'h0000_0000, busy});
      ce <= 1'b1;
      idle();
      rdc(exec_pkg::OFF_ACC, 32'h0000_0026, "acc after hold");
      print_verdict();
   end
endmodule : tb
